//--- hdl/s1ma_decode.sv
// Stage 1 memory attribute decode and hierarchical permission tracking
`timescale 1ns/1ps
`include "s1ma_defines.svh"

module s1ma_decode #(
  parameter bit HINT_IMPL = 1'b0
) (
  // Clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       rst_in,
  // Context descriptor held by the walker
  input  wire logic [`S1MA_CD_WIDTH-1:0]  context_descriptor_in,
  input  wire logic                       hier_attr_disable_lo_in,
  // Attribute lookup from a fetched translation descriptor
  input  wire logic                       attr_req_in,
  input  wire logic [2:0]                 attribute_index_in,
  // Table walk steps
  input  wire logic                       walk_start_in,
  input  wire logic                       walk_table_hi_in,
  input  wire logic                       tbl_step_in,
  input  wire s1ma_pkg::s1ma_tbl_perm_t   tbl_perm_in,
  // Results
  output logic                            attr_valid_out,
  output s1ma_pkg::s1ma_attr_t            attr_out,
  output s1ma_pkg::s1ma_tbl_perm_t        perm_limit_out,
  output logic [`S1MA_WORD_W-1:0]         hint_out
);
  import s1ma_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Decode functions

  // Indices 0..3 live in the low word, 4..7 in the high word
  function automatic logic [7:0] select_attr(
    input logic [`S1MA_CD_WIDTH-1:0] cd,
    input logic [2:0]                idx
  );
    logic [`S1MA_WORD_W-1:0] word;
    word = idx[2] ? cd[`S1MA_ATTR_HI_LSB +: `S1MA_WORD_W]   // R1
                  : cd[`S1MA_ATTR_LO_LSB +: `S1MA_WORD_W];  // R10
    return word[idx[1:0]*8 +: 8];
  endfunction

  function automatic logic [7:0] select_aux(
    input logic [`S1MA_CD_WIDTH-1:0] cd,
    input logic [2:0]                idx
  );
    logic [`S1MA_WORD_W-1:0] word;
    word = idx[2] ? cd[`S1MA_AUX_HI_LSB +: `S1MA_WORD_W]
                  : cd[`S1MA_AUX_LO_LSB +: `S1MA_WORD_W];
    return word[idx[1:0]*8 +: 8];
  endfunction

  // Reserved codes fold onto legal ones so eff_attr and memtype see only those; raw_attr keeps the code
  function automatic logic [7:0] remap_attr(input logic [7:0] a);
    logic [7:0] r;
    r = a;                                                  // R2
    if (a[7:4] != 4'h0 && a[3:0] == 4'h0) begin
      r = {a[7:4], `S1MA_TRANSIENT_WT};                     // R3
    end else if (a[7:4] == 4'h0 && a[1:0] != 2'h0) begin
      r = {4'h0, a[3:2], 2'h0};                             // R3
    end
    return r;
  endfunction

  function automatic s1ma_memtype_t attr_type(input logic [7:0] a);
    s1ma_memtype_t t;
    t = MT_NORMAL;
    if (a[7:4] == 4'h0) begin
      case (a[3:2])                                         // R4
        2'h0:    t = MT_DEVICE_STRICT_ORDER;
        2'h1:    t = MT_DEVICE_EARLY_ACK;
        2'h2:    t = MT_DEVICE_REORDER_EARLY_ACK;
        default: t = MT_DEVICE_GATHER_REORDER_ACK;
      endcase
    end
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Attribute lookup

  logic [7:0]  sel_raw;
  logic [7:0]  sel_eff;
  logic        aux_zero;
  s1ma_attr_t  attr_d;
  s1ma_attr_t  attr_q;
  logic        attr_valid_q;

  assign sel_raw  = select_attr(context_descriptor_in, attribute_index_in);
  assign sel_eff  = remap_attr(sel_raw);
  // Zero auxiliary words mean plain behaviour, no extensions
  assign aux_zero = context_descriptor_in[`S1MA_AUX_LO_LSB +: 64] == 64'h0;

  always_comb begin
    attr_d.raw_attr    = sel_raw;
    attr_d.eff_attr    = sel_eff;
    attr_d.memtype     = attr_type(sel_eff);
    attr_d.aux_generic = aux_zero;                          // R7
    attr_d.aux_attr    = aux_zero ? 8'h00                   // R7
                       : select_aux(context_descriptor_in,
                                    attribute_index_in);    // R5
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      attr_valid_q <= 1'b0;
    end else begin
      attr_valid_q <= attr_req_in;
    end
  end

  // Result holds between lookups
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      attr_q <= '0;
    end else if (attr_req_in) begin
      attr_q <= attr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Implementation hint field

  logic [`S1MA_WORD_W-1:0] hint_q;

  // Unimplemented here by default, so the field reads back as zero
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hint_q <= '0;
    end else begin
      hint_q <= HINT_IMPL ?
                context_descriptor_in[`S1MA_HINT_LSB +: `S1MA_WORD_W] :
                '0;                                         // R12
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Hierarchical permission limits

  logic           dis_q;
  logic           step_dis;
  s1ma_tbl_perm_t limit_q;

  // Disable picked per walk; start and first step may share a cycle
  assign step_dis = walk_start_in ?
                    (walk_table_hi_in ?
                     context_descriptor_in[`S1MA_HAD_HI_BIT] :  // R11
                     hier_attr_disable_lo_in) : dis_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dis_q <= 1'b0;
    end else if (walk_start_in) begin
      dis_q <= step_dis;
    end
  end

  // Limits only tighten during a walk: OR of all table levels so far; a disabled walk stays at zero
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      limit_q <= '0;
    end else if (tbl_step_in && !step_dis) begin
      limit_q <= (walk_start_in ? '0 : limit_q) | tbl_perm_in;  // R8
    end else if (walk_start_in) begin
      limit_q <= '0;                                        // R9
    end
  end

  assign attr_valid_out = attr_valid_q;
  assign attr_out       = attr_q;
  assign perm_limit_out = limit_q;
  assign hint_out       = hint_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_lookup_latency;
    @(posedge clk_in) disable iff (rst_in)
    attr_req_in |=> attr_valid_out ##1 (attr_valid_out == $past(attr_req_in));
  endproperty
  a_lookup_latency: assert property (p_lookup_latency)             // R1
    else $error("lookup answer not one cycle after request");

  property p_select;
    @(posedge clk_in) disable iff (rst_in)
    attr_req_in |=> attr_out.raw_attr ==
      select_attr($past(context_descriptor_in), $past(attribute_index_in));
  endproperty
  a_select: assert property (p_select)                             // R10
    else $error("wrong attribute byte selected");

  property p_normal_remap;
    @(posedge clk_in) disable iff (rst_in)
    attr_req_in && sel_raw[7:4] != 4'h0 && sel_raw[3:0] == 4'h0 |=>
      attr_out.eff_attr[3:0] == 4'h3 && attr_out.memtype == MT_NORMAL;
  endproperty
  a_normal_remap: assert property (p_normal_remap)                 // R3
    else $error("reserved normal code not remapped");

  property p_device_map;
    @(posedge clk_in) disable iff (rst_in)
    attr_req_in && sel_raw[7:4] == 4'h0 && sel_raw[3:2] == 2'h1 |=>
      attr_out.memtype == MT_DEVICE_EARLY_ACK;
  endproperty
  a_device_map: assert property (p_device_map)                     // R4
    else $error("device type mapping wrong");

  property p_standard_kept;
    @(posedge clk_in) disable iff (rst_in)
    attr_req_in && sel_raw[7:4] != 4'h0 && sel_raw[3:0] != 4'h0 |=>
      attr_out.eff_attr == attr_out.raw_attr;
  endproperty
  a_standard_kept: assert property (p_standard_kept)               // R2
    else $error("standard code altered");

  property p_aux_generic;
    @(posedge clk_in) disable iff (rst_in)
    attr_req_in && aux_zero |=> attr_out.aux_generic &&
      attr_out.aux_attr == 8'h00 ##1 attr_out.aux_generic || $past(attr_req_in);
  endproperty
  a_aux_generic: assert property (p_aux_generic)                   // R7
    else $error("zero auxiliary words not generic");

  property p_aux_carry;
    @(posedge clk_in) disable iff (rst_in)
    attr_req_in && !aux_zero |=> attr_out.aux_attr ==
      select_aux($past(context_descriptor_in), $past(attribute_index_in));
  endproperty
  a_aux_carry: assert property (p_aux_carry)                       // R5
    else $error("auxiliary byte not carried");

  property p_hier_accum;
    @(posedge clk_in) disable iff (rst_in)
    tbl_step_in && !step_dis && tbl_perm_in.table_user_exec_never |=>
      perm_limit_out.table_user_exec_never [*2] or walk_start_in[*1] ##1 1;
  endproperty
  a_hier_accum: assert property (p_hier_accum)                     // R8
    else $error("table limit not applied");

  property p_hier_disabled;
    @(posedge clk_in) disable iff (rst_in)
    tbl_step_in && step_dis && !walk_start_in |=> $stable(perm_limit_out);
  endproperty
  a_hier_disabled: assert property (p_hier_disabled)               // R9
    else $error("table bits used while disabled");

  property p_hint_off;
    @(posedge clk_in) disable iff (rst_in)
    !HINT_IMPL |-> hint_out == '0;
  endproperty
  a_hint_off: assert property (p_hint_off)                         // R12
    else $error("hint field not ignored");

  c_device: cover property (@(posedge clk_in) disable iff (rst_in)
    attr_valid_out && attr_out.memtype == MT_DEVICE_GATHER_REORDER_ACK);
  c_remap: cover property (@(posedge clk_in) disable iff (rst_in)
    attr_valid_out && attr_out.raw_attr != attr_out.eff_attr);
  c_walk: cover property (@(posedge clk_in) disable iff (rst_in)
    walk_start_in ##1 tbl_step_in ##1 tbl_step_in);

endmodule

//--- hdl/s1ma_defines.svh
// Field positions and constants for the stage 1 memory attribute decoder
// Function
// R1: Index selects 8-bit attribute from indirection words
// R2: Selected attribute uses standard memory-attribute encoding
// R3: Reserved encodings remap to defined memory types
// R4: Device reserved encodings map by lower-nibble top bits
// R5: Carry two 32-bit auxiliary attribute words
// R6: Unaware software writes auxiliary words as zero
// R7: Zero auxiliary words give generic standard behaviour
// R8: Table permission bits limit all lower levels
// R9: Disable flag makes table permission bits ignored
// R10: Lower indirection word sits at bits 223:192
// R11: Bit 129 disables hierarchical attributes, high region
// R12: Bits 351:320 are ignored implementation hint field
`ifndef S1MA_DEFINES_SVH
`define S1MA_DEFINES_SVH

`define S1MA_CD_WIDTH       352
`define S1MA_HAD_HI_BIT     129
`define S1MA_ATTR_LO_LSB    192
`define S1MA_ATTR_HI_LSB    224
`define S1MA_AUX_LO_LSB     256
`define S1MA_AUX_HI_LSB     288
`define S1MA_HINT_LSB       320
`define S1MA_WORD_W         32
`define S1MA_TRANSIENT_WT   4'h3

`endif

//--- hdl/s1ma_pkg.sv
// Types shared by the stage 1 memory attribute decoder
package s1ma_pkg;

  typedef enum logic [2:0] {
    MT_DEVICE_STRICT_ORDER,
    MT_DEVICE_EARLY_ACK,
    MT_DEVICE_REORDER_EARLY_ACK,
    MT_DEVICE_GATHER_REORDER_ACK,
    MT_NORMAL
  } s1ma_memtype_t;

  typedef struct packed {
    s1ma_memtype_t memtype;
    logic [7:0]    raw_attr;
    logic [7:0]    eff_attr;
    logic [7:0]    aux_attr;
    logic          aux_generic;
  } s1ma_attr_t;

  typedef struct packed {
    logic [1:0] table_access_limit;
    logic       table_priv_exec_never;
    logic       table_user_exec_never;
  } s1ma_tbl_perm_t;

endpackage

//--- tb/s1ma_walker_model.sv
// Table walker model driving the attribute decoder's request side
`timescale 1ns/1ps

module s1ma_walker_model (
  // Clock
  input  wire logic                 clk_in,
  // Descriptor image and lookups
  output logic [351:0]              cd_out,
  output logic                      had_lo_out,
  output logic                      req_out,
  output logic [2:0]                idx_out,
  // Walk steps
  output logic                      start_out,
  output logic                      hi_out,
  output logic                      step_out,
  output s1ma_pkg::s1ma_tbl_perm_t  perm_out
);
  import s1ma_pkg::*;

  initial begin
    cd_out     = '0;
    had_lo_out = 1'b0;
    req_out    = 1'b0;
    idx_out    = 3'h0;
    start_out  = 1'b0;
    hi_out     = 1'b0;
    step_out   = 1'b0;
    perm_out   = '0;
  end

  // Descriptor and lookup updates; callers apply them at the falling edge
  task set_word(input int lsb, input logic [31:0] w);
    cd_out[lsb +: 32] = w;
  endtask

  task set_disable(input logic lo, input logic hi);
    had_lo_out  = lo;
    cd_out[129] = hi;
  endtask

  task lookup(input logic r, input logic [2:0] i);
    req_out = r;
    idx_out = i;
  endtask

  // One-cycle walk pulse; a full cycle passes before the next one
  task walk(input logic st, input logic hi, input logic sp,
            input s1ma_tbl_perm_t p);
    @(negedge clk_in);
    start_out = st;
    hi_out    = hi;
    step_out  = sp;
    perm_out  = p;
    @(negedge clk_in);
    start_out = 1'b0;
    step_out  = 1'b0;
  endtask
endmodule

//--- tb/tb.sv
// Self-checking bench for the stage 1 memory attribute decoder
`timescale 1ns/1ps

module tb;
  import s1ma_pkg::*;

  typedef struct packed {
    logic [2:0] idx;
    logic [7:0] attr;
    logic [7:0] eff;
    logic [2:0] mt;
  } s1ma_row_t;

  logic           clk_in = 1'b0;
  logic           rst_in = 1'b1;
  logic [351:0]   cd;
  logic           had_lo, req, start, hi, step, valid;
  logic [2:0]     idx;
  s1ma_tbl_perm_t perm, lim;
  s1ma_attr_t     attr;
  logic [31:0]    hint;
  int             fail_count = 0;
  int             tests_run = 0;
  // Lo word bytes 0-3, hi word bytes 4-7
  s1ma_row_t rows [8] = '{
    '{3'h0, 8'h44, 8'h44, 3'h4}, '{3'h1, 8'hF0, 8'hF3, 3'h4},
    '{3'h2, 8'h01, 8'h00, 3'h0}, '{3'h3, 8'h06, 8'h04, 3'h1},
    '{3'h4, 8'h0B, 8'h08, 3'h2}, '{3'h5, 8'h0F, 8'h0C, 3'h3},
    '{3'h6, 8'h00, 8'h00, 3'h0}, '{3'h7, 8'hFF, 8'hFF, 3'h4}};

  always #50 clk_in = ~clk_in;

  s1ma_decode s1ma_decode_i (
    .clk_in(clk_in), .rst_in(rst_in), .context_descriptor_in(cd),
    .hier_attr_disable_lo_in(had_lo), .attr_req_in(req),
    .attribute_index_in(idx), .walk_start_in(start),
    .walk_table_hi_in(hi), .tbl_step_in(step), .tbl_perm_in(perm),
    .attr_valid_out(valid), .attr_out(attr), .perm_limit_out(lim),
    .hint_out(hint));

  s1ma_walker_model s1ma_walker_model_i (
    .clk_in(clk_in), .cd_out(cd), .had_lo_out(had_lo), .req_out(req),
    .idx_out(idx), .start_out(start), .hi_out(hi), .step_out(step),
    .perm_out(perm));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task print_verdict;
    if (fail_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Run is about 36 cycles; generous margin
  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    chk(valid, 32'h0);
    chk(attr, 32'h0);
    chk(lim, 32'h0);
    chk(hint, 32'h0);
    s1ma_walker_model_i.set_word(192, 32'h0601F044);
    s1ma_walker_model_i.set_word(224, 32'hFF000F0B);
    s1ma_walker_model_i.set_word(320, 32'hA5A5A5A5);
    // Back-to-back lookups, one per cycle
    for (int i = 0; i < 8; i++) begin
      s1ma_walker_model_i.lookup(1'b1, rows[i].idx);
      @(negedge clk_in);
      chk(valid, 32'h1);
      chk(attr.raw_attr, rows[i].attr);
      chk(attr.eff_attr, rows[i].eff);
      chk(attr.memtype, rows[i].mt);
      chk(attr.aux_generic, 32'h1);
      chk(attr.aux_attr, 32'h0);
    end
    s1ma_walker_model_i.lookup(1'b0, 3'h0);
    @(negedge clk_in);
    chk(valid, 32'h0);
    chk(hint, 32'h0);
    // Nonzero auxiliary words: one byte per index is carried
    s1ma_walker_model_i.set_word(256, 32'h00000011);
    s1ma_walker_model_i.set_word(288, 32'h0000AB00);
    s1ma_walker_model_i.lookup(1'b1, 3'h0);
    @(negedge clk_in);
    s1ma_walker_model_i.lookup(1'b1, 3'h5);
    chk(attr.aux_generic, 32'h0);
    chk(attr.aux_attr, 32'h11);
    chk(attr.eff_attr, 32'h44);
    @(negedge clk_in);
    s1ma_walker_model_i.lookup(1'b0, 3'h0);
    chk(attr.aux_attr, 32'hAB);
    chk(attr.eff_attr, 32'h0C);
    // Limits accumulate over levels
    s1ma_walker_model_i.walk(1'b1, 1'b0, 1'b0, 4'h0);
    chk(lim, 32'h0);
    s1ma_walker_model_i.walk(1'b0, 1'b0, 1'b1, 4'h1);
    chk(lim, 32'h1);
    s1ma_walker_model_i.walk(1'b0, 1'b0, 1'b1, 4'h4);
    chk(lim, 32'h5);
    s1ma_walker_model_i.set_disable(1'b1, 1'b0);
    s1ma_walker_model_i.walk(1'b1, 1'b0, 1'b0, 4'h0);
    chk(lim, 32'h0);
    s1ma_walker_model_i.walk(1'b0, 1'b0, 1'b1, 4'hF);
    chk(lim, 32'h0);
    s1ma_walker_model_i.set_disable(1'b1, 1'b1);
    s1ma_walker_model_i.walk(1'b1, 1'b1, 1'b0, 4'h0);
    s1ma_walker_model_i.walk(1'b0, 1'b1, 1'b1, 4'hF);
    chk(lim, 32'h0);
    s1ma_walker_model_i.set_disable(1'b1, 1'b0);
    s1ma_walker_model_i.walk(1'b1, 1'b1, 1'b0, 4'h0);
    s1ma_walker_model_i.walk(1'b0, 1'b1, 1'b1, 4'h8);
    chk(lim, 32'h8);
    // Start and step together: old limits dropped, step is first level
    s1ma_walker_model_i.walk(1'b1, 1'b1, 1'b1, 4'h2);
    chk(lim, 32'h2);
    // Mid-run reset clears every output
    rst_in = 1'b1;
    @(negedge clk_in);
    chk(valid, 32'h0);
    chk(attr, 32'h0);
    chk(lim, 32'h0);
    rst_in = 1'b0;
    s1ma_walker_model_i.lookup(1'b1, 3'h7);
    @(negedge clk_in);
    s1ma_walker_model_i.lookup(1'b0, 3'h0);
    chk(valid, 32'h1);
    chk(attr.raw_attr, 32'hFF);
    print_verdict();
  end
endmodule
